// >>> agc_loop.sv
// Purpose: Gain control loop: gain stage, magnitude, error scaler, limiter
// Assumes: Samples spaced at least 18 clocks apart for full loop updates
// Notes: Magnitude comes from a 16-step vectoring rotator on the output
`timescale 1ns/1ps
module agc_loop
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic [agc_pkg::PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Filter data in
   input wire logic firValid,
   input wire agc_pkg::wide_iq_t firSample,
   input wire logic loopGainSelect,
   // Scaled data out
   output logic outValid,
   output agc_pkg::iq_t outSample
);
   import agc_pkg::*;

   loop_param_t loopParams;
   gain_limits_t gainLimits;
   logic preserveAcc;
   logic backendReset;
   logic [GAIN_W-1:0] gain;
   logic [GAIN_W-1:0] appliedGain;

   // Bus decode

   logic access;
   logic commit;
   logic [7:0] regIdx;
   logic mapped;

   assign access = psel && penable;
   assign commit = access && pready;
   assign regIdx = paddr[9:2];

   always_comb
   begin
      mapped = 1'b0;
      if (paddr[1:0] == 2'b00 && paddr[PADDR_W-1:10] == '0)
      begin
         unique case (regIdx)
            IDX_LOOP, IDX_LIMIT, IDX_STATUS, IDX_BKRST, IDX_CONFIG:
               mapped = 1'b1;
            default:
               mapped = 1'b0;
         endcase
      end
   end

   // One wait state, answer on second access cycle
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= access && !pready;
         pslverr <= access && !pready && !mapped;
      end
   end

   // Write-only words read back as zero
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         prdata <= REG_RESET;
      else if (access && !pready)
      begin
         prdata <= REG_RESET;
         if (!pwrite && mapped)
         begin
            if (regIdx == IDX_STATUS)
               prdata <= {{(32-GAIN_W){1'b0}}, appliedGain};
            else if (regIdx == IDX_CONFIG)
               prdata <= {16'h0000, preserveAcc, 15'h0000};
         end
      end
   end

   // Registers

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         loopParams <= REG_RESET;
         gainLimits <= REG_RESET;
         preserveAcc <= 1'b0;
      end
      else if (commit && pwrite && mapped)
      begin
         if (regIdx == IDX_LOOP)
            loopParams <= pwdata;
         if (regIdx == IDX_LIMIT)
            gainLimits <= pwdata;
         if (regIdx == IDX_CONFIG)
            preserveAcc <= pwdata[PRESERVE_BIT];
      end
   end

   // Any write to the reset word fires the backend reset
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         backendReset <= 1'b0;
      else
         backendReset <= commit && pwrite && mapped && regIdx == IDX_BKRST;
   end

   // Gain stage

   agc_mult_shift u_mult_shift
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .inValid(firValid),
      .inSample(firSample),
      .gain(gain),
      .outValid(outValid),
      .outSample(outSample),
      .appliedGain(appliedGain)
   );

   // Magnitude by vectoring rotation

   mag_state_t magState;
   logic [3:0] iter;
   logic signed [CORD_W-1:0] vx;
   logic signed [CORD_W-1:0] vy;
   logic signed [CORD_W-1:0] sx;
   logic signed [CORD_W-1:0] sy;
   logic magStart;

   // New magnitude only when idle; busy samples still pass through
   assign magStart = magState == MAG_IDLE && outValid;
   assign sx = vx >>> iter;
   assign sy = vy >>> iter;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         magState <= MAG_IDLE;
      else
      begin
         unique case (magState)
            MAG_IDLE:
               if (outValid)
                  magState <= MAG_RUN;
            MAG_RUN:
               if (iter == CORD_LAST)
                  magState <= MAG_DONE;
            MAG_DONE:
               magState <= MAG_IDLE;
         endcase
      end
   end

   // Left half plane folded first; length unchanged by the fold
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vx <= '0;
         vy <= '0;
         iter <= '0;
      end
      else if (magStart)
      begin
         vx <= outSample.i[OUT_W-1] ? -CORD_W'(outSample.i) : CORD_W'(outSample.i);
         vy <= outSample.i[OUT_W-1] ? -CORD_W'(outSample.q) : CORD_W'(outSample.q);
         iter <= '0;
      end
      else if (magState == MAG_RUN)
      begin
         // Rotator gain of 1.64676 is kept, not divided out
         if (!vy[CORD_W-1])
         begin
            vx <= vx + sy;
            vy <= vy - sx;
         end
         else
         begin
            vx <= vx - sy;
            vy <= vy + sx;
         end
         iter <= iter + 4'h1;
      end
   end

   // Error detector and scaler

   loop_gain_t loopGain;
   logic [12:0] threshold;
   logic signed [ERR_W-1:0] magErr;
   logic signed [20:0] scaledErr;
   logic signed [20:0] stepErr;

   assign loopGain = loopGainSelect ? loopParams.gain1 : loopParams.gain0;
   assign threshold = {1'b0, loopParams.threshold[11:0]};
   // Magnitude LSB 2^-15 aligned to threshold LSB 2^-10
   assign magErr = $signed({3'b000, threshold}) - $signed({1'b0, vx[CORD_W-2:5]});
   assign scaledErr = magErr * $signed({1'b0, loopGain.mantissa});
   // Exponent sets a right shift of 15 minus its value on the scaled error
   assign stepErr = scaledErr >>> (~loopGain.exponent);

   // Loop filter

   logic [GAIN_W-1:0] upperGain;
   logic [GAIN_W-1:0] lowerGain;
   logic signed [GAIN_W+2:0] sum;
   logic [GAIN_W-1:0] next_gain;

   assign upperGain = {gainLimits.upper.exponent, 1'b0, gainLimits.upper.mantissa, 7'h00};
   assign lowerGain = {gainLimits.lower.exponent, 1'b0, gainLimits.lower.mantissa, 7'h00};
   assign sum = $signed({3'b000, gain}) + (GAIN_W+3)'(stepErr);

   // Lower limit wins if limits are crossed and the sum is below it; otherwise upper wins
   always_comb
   begin
      next_gain = gain;
      if (sum > $signed({3'b000, upperGain}))
         next_gain = upperGain;
      else if (!sum[GAIN_W+2])
         next_gain = sum[GAIN_W-1:0];
      if (sum < $signed({3'b000, lowerGain}))
         next_gain = lowerGain;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         gain <= GAIN_RESET;
      else if (backendReset && !preserveAcc)
         gain <= GAIN_RESET;
      else if (magState == MAG_DONE)
         gain <= next_gain;
   end

   // Checks

   property p_out_follows;
      @(posedge sys_clk) disable iff (!arst_n)
      firValid |=> outValid;
   endproperty
   a_out_follows: assert property (p_out_follows) else $error("sample not passed on");

   property p_gain_sampled;
      @(posedge sys_clk) disable iff (!arst_n)
      firValid |=> appliedGain == $past(gain);
   endproperty
   a_gain_sampled: assert property (p_gain_sampled) else $error("gain not taken at entry");

   property p_mag_time;
      @(posedge sys_clk) disable iff (!arst_n)
      magStart |-> ##17 magState == MAG_DONE;
   endproperty
   a_mag_time: assert property (p_mag_time) else $error("magnitude not ready in 17");

   property p_limits;
      @(posedge sys_clk) disable iff (!arst_n)
      magState == MAG_DONE && !backendReset && lowerGain <= upperGain
      |=> gain >= $past(lowerGain) && gain <= $past(upperGain);
   endproperty
   a_limits: assert property (p_limits) else $error("gain outside limits");

   property p_clear;
      @(posedge sys_clk) disable iff (!arst_n)
      backendReset && !preserveAcc |=> gain == GAIN_RESET;
   endproperty
   a_clear: assert property (p_clear) else $error("accumulator not cleared");

   property p_preserve;
      @(posedge sys_clk) disable iff (!arst_n)
      backendReset && preserveAcc && magState != MAG_DONE |=> $stable(gain);
   endproperty
   a_preserve: assert property (p_preserve) else $error("accumulator disturbed");

   property p_zero_loop;
      @(posedge sys_clk) disable iff (!arst_n)
      magState == MAG_DONE && loopGain.mantissa == 4'h0 && !backendReset
      && gain >= lowerGain && gain <= upperGain |=> $stable(gain);
   endproperty
   a_zero_loop: assert property (p_zero_loop) else $error("zero loop gain moved gain");

   property p_apb_wait;
      @(posedge sys_clk) disable iff (!arst_n)
      access && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("APB answer late");
endmodule

// >>> agc_loop_tb.sv
// Purpose: Self-checking bench for the gain control loop
// Assumes: Tiny outputs give a magnitude that truncates to zero error offset
// Notes: Seeded random data; expected gain is tracked here and checked against the status readback
`timescale 1ns/1ps
module agc_loop_tb;
   import agc_pkg::*;
   logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, err, b;
   logic [PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic firValid, loopGainSelect, outValid, go, sel;
   wide_iq_t firSample, goSample;
   iq_t outSample;
   logic [GAIN_W-1:0] cur;
   logic [7:0] m;
   int n_errors, checks;

   agc_loop dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .firValid(firValid),
      .firSample(firSample), .loopGainSelect(loopGainSelect), .outValid(outValid), .outSample(outSample));
   fir_stream_model src_u (.sys_clk(sys_clk), .arst_n(arst_n), .go(go), .goSample(goSample), .sel(sel),
      .firValid(firValid), .firSample(firSample), .loopGainSelect(loopGainSelect));

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task end_sim;
   begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
   begin
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask

   task give_up(input logic ok);
   begin
      if (ok !== 1'b1)
      begin
         n_errors++;
         end_sim;
      end
   end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
   begin
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      // Sampled at the rising edge that commits the transfer
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      give_up(pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   // Fixed point model of shift, fine multiply and saturation
   function automatic logic [15:0] scale(input logic signed [25:0] x, input logic [19:0] g);
      longint p;
   begin
      p = (longint'(x) * (65536 + longint'(g[15:0]))) <<< g[19:16];
      p = p >>> 26;
      if (p > 32767)
         p = 32767;
      else if (p < -32768)
         p = -32768;
      scale = p[15:0];
   end
   endfunction

   // Zero magnitude leaves error equal to threshold 256, set 1 is 15 at shift 0
   function automatic logic [19:0] step(input logic [19:0] g, input logic s, input logic [19:0] hi);
      longint t;
   begin
      t = g + (s ? (256 * 15) >>> (15 - 15) : 0);
      if (t > hi)
         t = hi;
      step = t[19:0];
   end
   endfunction

   function automatic wide_iq_t tiny_iq();
   begin
      tiny_iq.i = 26'($urandom_range(8190)) - 26'd4095;
      tiny_iq.q = 26'($urandom_range(8190)) - 26'd4095;
   end
   endfunction

   task send(input wide_iq_t x, input logic [19:0] g);
      int n;
   begin
      @(posedge sys_clk);
      go <= 1'b1;
      goSample <= x;
      @(posedge sys_clk);
      go <= 1'b0;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (outValid !== 1'b1 && n < 10);
      give_up(outValid);
      chk(outSample, {scale(x.i, g), scale(x.q, g)});
      // Leave the rotator and accumulator time to settle
      repeat (20) @(posedge sys_clk);
      apb(1'b0, 12'h028, 32'h0);
      chk(rd, {12'h0, g});
   end
   endtask

   initial
   begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      go = 1'b0;
      sel = 1'b0;
      goSample = '0;
      n_errors = 0;
      checks = 0;
      cur = '0;
      void'($urandom(32'hb399));
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      apb(1'b0, 12'h06c, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({rd[31:1], err}, 32'h0);
      apb(1'b1, 12'h030, 32'h1);
      chk(err, 1'b1);
      apb(1'b0, 12'h022, 32'h0);
      chk(err, 1'b1);
      repeat (4) send(tiny_iq(), cur);
      // Equal limits pin the gain; every exponent once
      apb(1'b1, 12'h020, 32'h0);
      for (int e = 0; e < 16; e++)
      begin
         m = 8'($urandom_range(255));
         sel <= 1'($urandom);
         apb(1'b1, 12'h024, {4'h0, 4'(e), m, 4'h0, 4'(e), m});
         send(tiny_iq(), cur);
         cur = {4'(e), 1'b0, m, 7'h0};
         send(52'({$urandom, $urandom}), cur);
      end
      send({26'h1ffffff, 26'h0000001}, cur);
      send({26'h0000001, 26'h2000000}, cur);
      // Threshold top bit set must be ignored; set 0 frozen, set 1 fast
      apb(1'b1, 12'h020, 32'h1100_ff00);
      apb(1'b1, 12'h024, 32'h0100_0000);
      apb(1'b1, 12'h064, 32'h0);
      cur = '0;
      for (int k = 0; k < 28; k++)
      begin
         b = (k >= 10) || 1'($urandom);
         sel <= b;
         send(tiny_iq(), cur);
         cur = step(cur, b, 20'h10000);
      end
      // Preserve bit keeps the accumulator across a backend reset
      sel <= 1'b0;
      apb(1'b1, 12'h06c, 32'h0000_8000);
      apb(1'b0, 12'h06c, 32'h0);
      chk(rd, 32'h0000_8000);
      apb(1'b1, 12'h064, 32'h0);
      send(tiny_iq(), cur);
      apb(1'b1, 12'h06c, 32'h0);
      apb(1'b1, 12'h064, 32'h0);
      send(tiny_iq(), 20'h0);
      end_sim;
   end
endmodule

// >>> agc_mult_shift.sv
// Purpose: Per-path gain stage, shift by exponent and fine multiply
// Assumes: Gain word is exponent over a 16-bit fraction
// Notes: Output register doubles as the sample handed downstream
`timescale 1ns/1ps
module agc_mult_shift
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Incoming filter data
   input wire logic inValid,
   input wire agc_pkg::wide_iq_t inSample,
   input wire logic [agc_pkg::GAIN_W-1:0] gain,
   // Scaled data
   output logic outValid,
   output agc_pkg::iq_t outSample,
   output logic [agc_pkg::GAIN_W-1:0] appliedGain
);
   import agc_pkg::*;

   logic signed [IN_W-1:0] inArr [2];
   logic signed [OUT_W-1:0] outArr [2];

   assign inArr[0] = inSample.i;
   assign inArr[1] = inSample.q;
   assign outSample = '{i: outArr[0], q: outArr[1]};

   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_path
         logic signed [43:0] prod;
         logic signed [59:0] shifted;
         logic ovf;
         // 1+X at 16-bit resolution, then 2^N shift
         assign prod = inArr[p] * $signed({2'b01, gain[MANT_W-1:0]});
         assign shifted = 60'(prod) <<< gain[GAIN_W-1:MANT_W];
         assign ovf = !((&shifted[59:41]) || !(|shifted[59:41]));
         always_ff @(posedge sys_clk or negedge arst_n)
         begin
            if (!arst_n)
               outArr[p] <= '0;
            else if (inValid)
            begin
               if (ovf)
                  outArr[p] <= shifted[59] ? SAT_NEG : SAT_POS;
               else
                  outArr[p] <= shifted[41:26];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         outValid <= 1'b0;
         appliedGain <= GAIN_RESET;
      end
      else
      begin
         outValid <= inValid;
         if (inValid)
            appliedGain <= gain;
      end
   end

   property p_unity;
      @(posedge sys_clk) disable iff (!arst_n)
      inValid && gain == GAIN_RESET |=> outSample.i == $past(inSample.i[25:10]);
   endproperty
   a_unity: assert property (p_unity) else $error("unity gain path wrong");

   property p_sat_pos;
      @(posedge sys_clk) disable iff (!arst_n)
      inValid && gain[19:16] == 4'hf && !inSample.i[25] && inSample.i[25:10] != 16'h0000
      |=> outSample.i == SAT_POS;
   endproperty
   a_sat_pos: assert property (p_sat_pos) else $error("I path did not saturate");
endmodule

// >>> agc_pkg.sv
// Purpose: Shared constants and types for the baseband gain control loop
// Assumes: 10 MHz sys_clk, APB register access, one sample per slot
// Notes: Register index times four gives the byte address
// Summary of operation
// - Raise 26-bit filter data into 16 bits
// - Samples out; magnitude feeds error, scaler, accumulator
// - Gain sampled as each sample enters
// - Saturate I and Q independently on overflow
// - Coarse gain is left shift 0 to 15
// - Fine gain multiplies by one plus mantissa
// - Fine mantissa kept at 16-bit resolution
// - Magnitude is 1.64676 times vector length
// - Error is threshold minus magnitude
// - Threshold 13 bits, top bit forced zero
// - Loop gain: 4-bit mantissa, 4-bit exponent
// - Two loop gain sets in bits 0-15
// - Select input low picks set 0
// - Scaled error bounded by 2.18344 maximum
// - Accumulator clamped between programmed limits
// - Limits are 8-bit mantissa, 4-bit exponent
// - Upper limit bits 16-27, lower 0-11
// - Backend reset clears accumulator unless preserved
package agc_pkg;
   localparam int IN_W = 26;
   localparam int OUT_W = 16;
   localparam int GAIN_W = 20;
   localparam int MANT_W = 16;
   localparam int CORD_W = 20;
   localparam int ERR_W = 16;
   localparam int PADDR_W = 12;
   localparam logic [3:0] CORD_LAST = 4'hf;
   localparam logic [7:0] IDX_LOOP = 8'h08;
   localparam logic [7:0] IDX_LIMIT = 8'h09;
   localparam logic [7:0] IDX_STATUS = 8'h0a;
   localparam logic [7:0] IDX_BKRST = 8'h19;
   localparam logic [7:0] IDX_CONFIG = 8'h1b;
   localparam int PRESERVE_BIT = 15;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [GAIN_W-1:0] GAIN_RESET = 20'h00000;
   localparam logic [OUT_W-1:0] SAT_POS = 16'h7fff;
   localparam logic [OUT_W-1:0] SAT_NEG = 16'h8000;

   typedef struct packed
   {
      logic signed [IN_W-1:0] i;
      logic signed [IN_W-1:0] q;
   } wide_iq_t;

   typedef struct packed
   {
      logic signed [OUT_W-1:0] i;
      logic signed [OUT_W-1:0] q;
   } iq_t;

   typedef struct packed
   {
      logic [3:0] exponent;
      logic [3:0] mantissa;
   } loop_gain_t;

   typedef struct packed
   {
      logic [2:0] unused;
      logic [12:0] threshold;
      loop_gain_t gain1;
      loop_gain_t gain0;
   } loop_param_t;

   typedef struct packed
   {
      logic [3:0] exponent;
      logic [7:0] mantissa;
   } limit_t;

   typedef struct packed
   {
      logic [3:0] unusedHi;
      limit_t upper;
      logic [3:0] unusedLo;
      limit_t lower;
   } gain_limits_t;

   typedef enum logic [2:0]
   {
      MAG_IDLE = 3'b001,
      MAG_RUN = 3'b010,
      MAG_DONE = 3'b100
   } mag_state_t;
endpackage

// >>> fir_stream_model.sv
// Purpose: Upstream filter stand-in feeding the gain loop
// Assumes: Bench asks for one sample at a time
// Notes: Sample bus inverts every cycle between pulses so stale data matches the sample only on alternate cycles
`timescale 1ns/1ps
module fir_stream_model
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Bench requests
   input wire logic go,
   input wire agc_pkg::wide_iq_t goSample,
   input wire logic sel,
   // Towards the gain loop
   output logic firValid,
   output agc_pkg::wide_iq_t firSample,
   output logic loopGainSelect
);
   import agc_pkg::*;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         firValid <= 1'b0;
         firSample <= '0;
         loopGainSelect <= 1'b0;
      end
      else
      begin
         firValid <= go;
         firSample <= go ? goSample : ~firSample;
         loopGainSelect <= sel;
      end
   end
endmodule
